// ---- rtl/flash_sec_pkg.sv ----
// Constants for the memory security and nonvolatile clock divider block.
// Assumes a 32-bit AHB-Lite slave with word-aligned register offsets.
package flash_sec_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CLK_DIV  = 8'h00;
  localparam logic [7:0] OFF_OPTION   = 8'h04;
  localparam logic [7:0] OFF_CONFIG   = 8'h08;
  localparam logic [7:0] OFF_PROTECT  = 8'h0c;
  localparam logic [7:0] OFF_STATUS   = 8'h10;
  localparam logic [7:0] OFF_KEY_BASE = 8'h20;
  localparam logic [7:0] OFF_KEY_LAST = 8'h3c;

  // Clock divider register fields
  localparam int DIVISOR_LOADED_FLAG_BIT     = 7;
  localparam int PRESCALE_BIT  = 6;
  localparam int DIV_MSB       = 5;
  localparam int DIV_W         = 6;
  localparam logic [7:0] CLK_DIV_RST = 8'h00;

  // Working option register fields
  localparam int BACKDOOR_KEY_ENABLE_BIT     = 7;
  localparam int NORED_BIT     = 6;
  localparam logic [7:0] OPTION_MASK = 8'hc3;
  localparam logic [7:0] OPTION_RST  = 8'h03;

  // Configuration register fields
  localparam int KEY_WRITE_ACCESS_BIT    = 5;
  localparam logic [7:0] CONFIG_MASK = 8'he0;
  localparam logic [7:0] CONFIG_RST  = 8'h00;

  // Protection register
  localparam logic [7:0] PROTECT_MASK = 8'hf8;
  localparam logic [7:0] PROTECT_RST  = 8'h00;

  // Security codes
  localparam logic [1:0] SEC_UNSECURED = 2'b10;

  // Clock divider
  localparam int PRESCALE_DIV  = 8;
  localparam int PRE_CNT_W     = 3;

  // Backdoor key
  localparam int KEY_BYTES     = 8;
  localparam int KEY_IDX_W     = 3;

  // AHB constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

endpackage : flash_sec_pkg

// ---- rtl/nvm_clock_divider.sv ----
// Nonvolatile memory clock generator: one-cycle tick per internal period.
// Assumes a single core clock; divisor is stable once loaded.
`timescale 1ns/1ns
module nvm_clock_divider #(
  parameter int DIV_W = 6
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic             prescale,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);

  localparam int PW = flash_sec_pkg::PRE_CNT_W;
  localparam logic [PW-1:0] PRE_LAST =
    PW'(flash_sec_pkg::PRESCALE_DIV - 1);

  logic [PW-1:0]    pre_cnt_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic             tick_r;
  wire              pre_en   = !prescale || (pre_cnt_r == PRE_LAST);
  wire              div_last = (div_cnt_r == divisor);

  // Divide by eight first when selected
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      pre_cnt_r <= '0;
    else if (!run || !prescale)
      pre_cnt_r <= '0;
    else
      pre_cnt_r <= pre_cnt_r + PW'(1);
  end

  // Divide the selected input by divisor plus one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_r <= '0;
      tick_r    <= 1'b0;
    end else if (!run) begin
      div_cnt_r <= '0;
      tick_r    <= 1'b0;
    end else begin
      tick_r <= pre_en && div_last;
      if (pre_en)
        div_cnt_r <= div_last ? '0 : div_cnt_r + DIV_W'(1);
    end
  end

  assign tick = tick_r;

endmodule : nvm_clock_divider

// ---- rtl/backdoor_key_match.sv ----
// Backdoor key comparison: tracks ordered key writes during a session.
// Assumes writes arrive one at a time with index and byte.
`timescale 1ns/1ns
module backdoor_key_match #(
  parameter int KEY_BYTES = 8,
  parameter int IDX_W     = 3
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 open_s,
  input  wire logic                 close_s,
  input  wire logic                 wr,
  input  wire logic [IDX_W-1:0]     idx,
  input  wire logic [7:0]           data,
  input  wire logic [KEY_BYTES*8-1:0] stored_key,
  output logic                      match
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ENTRY = 3'b010,
    ST_FULL  = 3'b100
  } key_state_t;

  key_state_t     state_r;
  logic [IDX_W:0] count_r;
  logic           bad_r;
  logic           match_r;

  wire [7:0] want     = stored_key[idx*8 +: 8];
  wire       in_order = ({1'b0, idx} == count_r);
  wire       good     = in_order && (data == want);
  wire       last     = (count_r == (IDX_W+1)'(KEY_BYTES - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      count_r <= '0;
      bad_r   <= 1'b0;
      match_r <= 1'b0;
    end else begin
      match_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (open_s) begin
            state_r <= ST_ENTRY;
            count_r <= '0;
            bad_r   <= 1'b0;
          end
        end
        ST_ENTRY: begin
          if (close_s) begin
            state_r <= ST_IDLE;
          end else if (wr) begin
            bad_r   <= bad_r || !good;
            count_r <= count_r + (IDX_W+1)'(1);
            if (last)
              state_r <= ST_FULL;
          end
        end
        ST_FULL: begin
          if (close_s) begin
            state_r <= ST_IDLE;
            match_r <= !bad_r;
          end else if (wr) begin
            bad_r <= 1'b1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign match = match_r;

endmodule : backdoor_key_match

// ---- rtl/flash_security_ctl.sv ----
// Memory security gate, backdoor key unlock and nonvolatile clock divider.
// Assumes an AHB-Lite master with source attributes and option bytes
// held stable by the nonvolatile array while reset is released.
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns

// Function
// - Secured: block memory access from unsecured code or debug.
// - Only code 1:0 means unsecured; all others secured.
// - Each reset copies the option byte into the working option register.
// - Debug module cannot be enabled while secured.
// - Background commands served; active background only via reset strap.
// - Key enable clear: only full erase can unsecure.
// - Key access set: key location writes become comparison values.
// - Key access cleared after matching eight writes unsecures until reset.
// - Key entry accepted only from code in secure memory.
// - Protection register writable only by background debug.
// - Passing blank check unsecures until next reset.
// - Divider bit 7 read-only; low bits take only first write.
// - Reset clears loaded flag; first divider write sets it.
// - No program or erase while loaded flag clear.
// - Prescale bit selects bus clock or bus clock divided by eight.
// - Divider divides its input by divisor plus one.
// - Timing pulses last one internal clock period, whole counts; PE_TIMING_PULSE is one core clock cycle once per internal period.
module flash_security_ctl (
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  input  wire logic        BUS_FROM_SECURE,
  input  wire logic        BUS_FROM_DEBUG,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Nonvolatile contents
  input  wire logic [7:0]  NV_OPTION_BYTE,
  input  wire logic [7:0]  NV_PROTECT_BYTE,
  input  wire logic [63:0] BACKDOOR_COMPARE_KEY,
  input  wire logic        BLANK_CHECK_PASS,
  // Background mode strap
  input  wire logic        BACKGROUND_MODE_SELECT_PIN,
  // Memory access gate
  input  wire logic        MEM_REQ,
  input  wire logic        MEM_WRITE,
  input  wire logic        MEM_FROM_SECURE,
  input  wire logic [7:0]  MEM_RDATA_RAW,
  output logic             MEM_WRITE_EN,
  output logic [7:0]       MEM_RDATA,
  // Debug and program/erase control
  input  wire logic        DEBUG_MODULE_REQ,
  input  wire logic        PE_REQ,
  output logic             DEBUG_MODULE_EN,
  output logic             ACTIVE_BACKGROUND_EN,
  output logic             PE_GRANT,
  output logic             PE_TIMING_PULSE,
  output logic             SECURED,
  output logic [7:0]       PROTECT_OUT
);

  // Word offset of an address
  function automatic logic [7:0] word_off(input logic [31:0] a);
    word_off = {a[7:2], 2'b00};
  endfunction : word_off

  // Is this offset inside the key window
  function automatic logic in_key(input logic [7:0] o);
    in_key = (o >= flash_sec_pkg::OFF_KEY_BASE) &&
             (o <= flash_sec_pkg::OFF_KEY_LAST);
  endfunction : in_key

  // State
  logic [7:0]  clk_div_r;
  logic [1:0]  sec_code_r;
  logic [7:0]  option_r;
  logic [7:0]  config_r;
  logic [7:0]  protect_r;
  logic        load_pend_r;

  // Data phase attributes
  logic        dp_wr_r;
  logic [7:0]  dp_off_r;
  logic        dp_sec_r;
  logic        dp_dbg_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  logic        hresp_r;

  // Output flops
  logic        mem_we_r;
  logic [7:0]  mem_rd_r;
  logic        dbg_en_r;
  logic        act_bg_r;
  logic        pe_grant_r;
  logic        pe_pulse_r;
  logic        secured_r;
  logic [7:0]  protect_out_r;

  // Submodule results
  logic        unlock_match;
  logic        fclk_tick;

  // Address phase decode
  wire       addr_take = HSEL && HREADY && HTRANS[1];
  wire [7:0] a_off     = word_off(HADDR);

  // Data phase decode
  wire       wr_div    = dp_wr_r &&
                         (dp_off_r == flash_sec_pkg::OFF_CLK_DIV);
  wire       wr_cfg    = dp_wr_r &&
                         (dp_off_r == flash_sec_pkg::OFF_CONFIG);
  wire       wr_prot   = dp_wr_r &&
                         (dp_off_r == flash_sec_pkg::OFF_PROTECT);
  wire       wr_key    = dp_wr_r && in_key(dp_off_r);
  wire [7:0] wbyte     = HWDATA[7:0];

  wire       divisor_loaded_flag     = clk_div_r[flash_sec_pkg::DIVISOR_LOADED_FLAG_BIT];
  wire       backdoor_key_enable     = option_r[flash_sec_pkg::BACKDOOR_KEY_ENABLE_BIT];
  wire       key_write_access    = config_r[flash_sec_pkg::KEY_WRITE_ACCESS_BIT];
  wire       is_secure = (sec_code_r != flash_sec_pkg::SEC_UNSECURED);

  // Key access bit edges from secure software
  wire       cfg_ok    = wr_cfg && dp_sec_r && !dp_dbg_r;
  wire       key_write_access_n  = wbyte[flash_sec_pkg::KEY_WRITE_ACCESS_BIT];
  wire       key_open  = cfg_ok && key_write_access_n && !key_write_access && backdoor_key_enable;
  wire       key_close = cfg_ok && !key_write_access_n && key_write_access;
  wire       key_wr    = wr_key && key_write_access && dp_sec_r && !dp_dbg_r;
  wire [2:0] key_idx   = 3'((dp_off_r - flash_sec_pkg::OFF_KEY_BASE) >> 2);
  wire       unlock    = (unlock_match && backdoor_key_enable) || BLANK_CHECK_PASS;

  // Memory gate decision
  wire       mem_block = is_secure && !MEM_FROM_SECURE;
  wire       mem_wr_ok = MEM_REQ && MEM_WRITE && !mem_block;
  wire       mem_rd_ok = MEM_REQ && !MEM_WRITE && !mem_block;

  // Program/erase needs a loaded divisor
  wire       pe_ok     = PE_REQ && divisor_loaded_flag;

  // Read selects for the address phase
  wire       sel_div  = (a_off == flash_sec_pkg::OFF_CLK_DIV);
  wire       sel_opt  = (a_off == flash_sec_pkg::OFF_OPTION);
  wire       sel_cfg  = (a_off == flash_sec_pkg::OFF_CONFIG);
  wire       sel_prot = (a_off == flash_sec_pkg::OFF_PROTECT);
  wire       sel_stat = (a_off == flash_sec_pkg::OFF_STATUS);
  wire [7:0] stat_byte = {4'h0, dbg_en_r, act_bg_r, divisor_loaded_flag, is_secure};

  // One-hot read mux; key bytes and holes read zero
  wire [7:0] rd_byte   = ({8{sel_div}}  & clk_div_r) |
                         ({8{sel_opt}}  & option_r)  |
                         ({8{sel_cfg}}  & config_r)  |
                         ({8{sel_prot}} & protect_r) |
                         ({8{sel_stat}} & stat_byte);

  // Address-phase attributes kept for the data phase
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dp_wr_r  <= 1'b0;
      dp_off_r <= 8'h00;
      dp_sec_r <= 1'b0;
      dp_dbg_r <= 1'b0;
    end else begin
      dp_wr_r  <= addr_take && HWRITE;
      dp_off_r <= a_off;
      dp_sec_r <= BUS_FROM_SECURE;
      dp_dbg_r <= BUS_FROM_DEBUG;
    end
  end

  // Read data loaded at the end of the address phase
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      hrdata_r <= 32'h0000_0000;
    else if (addr_take && !HWRITE)
      hrdata_r <= {24'h00_0000, rd_byte};
  end

  // Zero wait states, always OKAY
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  // Reset copy of option and protection bytes, taken after release
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      load_pend_r <= 1'b1;
    else
      load_pend_r <= 1'b0;
  end

  // Working option register, copied once per reset
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      option_r <= flash_sec_pkg::OPTION_RST;
    else if (load_pend_r)
      option_r <= NV_OPTION_BYTE & flash_sec_pkg::OPTION_MASK;
  end

  // Security code: reloaded at reset, opened by an unlock
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      sec_code_r <= flash_sec_pkg::OPTION_RST[1:0];
    else if (load_pend_r)
      sec_code_r <= NV_OPTION_BYTE[1:0];
    else if (unlock)
      sec_code_r <= flash_sec_pkg::SEC_UNSECURED;
  end

  // Protection register; only background debug may write it
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      protect_r <= flash_sec_pkg::PROTECT_RST;
    else if (load_pend_r)
      protect_r <= NV_PROTECT_BYTE & flash_sec_pkg::PROTECT_MASK;
    else if (wr_prot && dp_dbg_r)
      protect_r <= wbyte & flash_sec_pkg::PROTECT_MASK;
  end

  // Configuration register: key access from secure code only
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      config_r <= flash_sec_pkg::CONFIG_RST;
    else if (key_open || key_close)
      config_r <= wbyte & flash_sec_pkg::CONFIG_MASK;
    else if (cfg_ok && !key_write_access_n)
      config_r <= wbyte & flash_sec_pkg::CONFIG_MASK;
  end

  // Clock divider register: write-once low bits, read-only flag
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      clk_div_r <= flash_sec_pkg::CLK_DIV_RST;
    else if (wr_div && !divisor_loaded_flag)
      clk_div_r <= {1'b1, wbyte[6:0]};
  end

  // Registered memory write gate
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      mem_we_r <= 1'b0;
    else
      mem_we_r <= mem_wr_ok;
  end

  // Registered memory read gate; blocked reads give zero
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      mem_rd_r <= 8'h00;
    else
      mem_rd_r <= mem_rd_ok ? MEM_RDATA_RAW : 8'h00;
  end

  // Background strap caught at reset release
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      act_bg_r <= 1'b0;
    else if (load_pend_r)
      act_bg_r <= !BACKGROUND_MODE_SELECT_PIN;
  end

  // Debug module enable only while unsecured
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      dbg_en_r <= 1'b0;
    else
      dbg_en_r <= DEBUG_MODULE_REQ && !is_secure;
  end

  // Program/erase grant and timing pulses
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pe_grant_r <= 1'b0;
      pe_pulse_r <= 1'b0;
    end else begin
      pe_grant_r <= pe_ok;
      pe_pulse_r <= pe_ok && fclk_tick;
    end
  end

  // Security state pin
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      secured_r <= 1'b1;
    else
      secured_r <= is_secure;
  end

  // Protection copy pin
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      protect_out_r <= flash_sec_pkg::PROTECT_RST;
    else
      protect_out_r <= protect_r;
  end

  // Internal nonvolatile clock runs once divisor is loaded
  nvm_clock_divider #(
    .DIV_W    (flash_sec_pkg::DIV_W)
  ) u_div (
    .clk      (CORE_CLK),
    .rst      (SYS_RST),
    .run      (divisor_loaded_flag),
    .prescale (clk_div_r[flash_sec_pkg::PRESCALE_BIT]),
    .divisor  (clk_div_r[flash_sec_pkg::DIV_MSB:0]),
    .tick     (fclk_tick)
  );

  // Ordered key comparison
  backdoor_key_match #(
    .KEY_BYTES  (flash_sec_pkg::KEY_BYTES),
    .IDX_W      (flash_sec_pkg::KEY_IDX_W)
  ) u_key (
    .clk        (CORE_CLK),
    .rst        (SYS_RST),
    .open_s     (key_open),
    .close_s    (key_close),
    .wr         (key_wr),
    .idx        (key_idx),
    .data       (wbyte),
    .stored_key (BACKDOOR_COMPARE_KEY),
    .match      (unlock_match)
  );

  assign HRDATA               = hrdata_r;
  assign HREADYOUT            = hreadyout_r;
  assign HRESP                = hresp_r;
  assign MEM_WRITE_EN         = mem_we_r;
  assign MEM_RDATA            = mem_rd_r;
  assign DEBUG_MODULE_EN      = dbg_en_r;
  assign ACTIVE_BACKGROUND_EN = act_bg_r;
  assign PE_GRANT             = pe_grant_r;
  assign PE_TIMING_PULSE      = pe_pulse_r;
  assign SECURED              = secured_r;
  assign PROTECT_OUT          = protect_out_r;

endmodule : flash_security_ctl

// ---- test/flash_security_ctl_chk.sv ----
// Port checker for the security gate and nonvolatile clock divider.
// Assumes one clock domain; bound to flash_security_ctl by port name.
`timescale 1ns/1ns
module flash_security_ctl_chk (
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic        HSEL,
  input wire logic        HREADY,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HADDR,
  input wire logic        BUS_FROM_DEBUG,
  input wire logic [7:0]  NV_OPTION_BYTE,
  input wire logic        MEM_REQ,
  input wire logic        MEM_WRITE,
  input wire logic        MEM_FROM_SECURE,
  input wire logic        MEM_WRITE_EN,
  input wire logic [7:0]  MEM_RDATA,
  input wire logic        DEBUG_MODULE_REQ,
  input wire logic        DEBUG_MODULE_EN,
  input wire logic        PE_GRANT,
  input wire logic        PE_TIMING_PULSE,
  input wire logic        SECURED,
  input wire logic [7:0]  PROTECT_OUT
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  wire  take = HSEL && HREADY && HTRANS[1] && HWRITE;
  logic div_r;
  logic prot_r;
  // Divider written once; debug write to protection seen
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      div_r  <= 1'b0;
      prot_r <= 1'b0;
    end else begin
      div_r  <= div_r | (take && HADDR[7:0] == flash_sec_pkg::OFF_CLK_DIV);
      prot_r <= take && BUS_FROM_DEBUG &&
                HADDR[7:0] == flash_sec_pkg::OFF_PROTECT;
    end
  end
  a_wr_block: assert property (
    MEM_REQ && MEM_WRITE && !MEM_FROM_SECURE && SECURED ##1 SECURED
    |-> !MEM_WRITE_EN) else $error("memory write passed while secured");
  a_rd_zero: assert property (
    MEM_REQ && !MEM_WRITE && !MEM_FROM_SECURE && SECURED ##1 SECURED
    |-> MEM_RDATA == 8'h00) else $error("memory read not zero");
  a_src_pass: assert property (
    MEM_REQ && MEM_FROM_SECURE |=> MEM_WRITE_EN == $past(MEM_WRITE))
    else $error("secure source access not served");
  a_dbg_block: assert property (
    DEBUG_MODULE_EN |-> !SECURED) else $error("debug enabled while secured");
  a_dbg_allow: assert property (
    !SECURED && DEBUG_MODULE_REQ |=> DEBUG_MODULE_EN)
    else $error("debug refused while unsecured");
  a_code_load: assert property (
    $fell(SYS_RST) |-> ##2 SECURED ==
      (NV_OPTION_BYTE[1:0] != flash_sec_pkg::SEC_UNSECURED))
    else $error("security state not loaded from option byte");
  a_pe_loaded: assert property (
    PE_GRANT || PE_TIMING_PULSE |-> div_r)
    else $error("program or erase before divider written");
  a_prot_src: assert property (
    $changed(PROTECT_OUT) |-> $past(prot_r, 2) || $past(SYS_RST, 3))
    else $error("protection changed without debug write");
  c_unlock: cover property ($fell(SECURED));
  c_pulse: cover property (PE_TIMING_PULSE);
  c_dbg: cover property (DEBUG_MODULE_EN);
endmodule : flash_security_ctl_chk

bind flash_security_ctl flash_security_ctl_chk chk_i (.*);

// ---- test/ahb_core_model.sv ----
// Bus master model of the core and background debug controller.
// Assumes a zero or multi wait slave; single word transfers only.
`timescale 1ns/1ns
module ahb_core_model (
  input  wire logic        CORE_CLK,
  input  wire logic        HREADY,
  input  wire logic [31:0] HRDATA,
  output logic             HSEL,
  output logic [31:0]      HADDR,
  output logic [1:0]       HTRANS,
  output logic             HWRITE,
  output logic [2:0]       HSIZE,
  output logic [31:0]      HWDATA,
  output logic             BUS_FROM_SECURE,
  output logic             BUS_FROM_DEBUG
);
  initial begin
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    BUS_FROM_SECURE = 1'b0;
    BUS_FROM_DEBUG = 1'b0;
  end
  // Source attributes travel with the address phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic s, input logic g, output logic [31:0] q);
    @(posedge CORE_CLK);
    HSEL <= 1'b1;
    HTRANS <= flash_sec_pkg::HTRANS_NONSEQ;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    BUS_FROM_SECURE <= s;
    BUS_FROM_DEBUG <= g;
    do @(posedge CORE_CLK); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= {24'h0, d};
    do @(posedge CORE_CLK); while (HREADY !== 1'b1);
    q = HRDATA;
    HWDATA <= ~HWDATA;
    @(posedge CORE_CLK);
  endtask : xfer
endmodule : ahb_core_model

// ---- test/test_flash_security_ctl.sv ----
// Self-checking bench for the security gate and clock divider.
// Assumes the core model as bus master and the bound checker.
`timescale 1ns/1ns
module test_flash_security_ctl;
  logic CORE_CLK, SYS_RST, BLANK_CHECK_PASS, BACKGROUND_MODE_SELECT_PIN;
  logic MEM_REQ, MEM_WRITE, MEM_FROM_SECURE, DEBUG_MODULE_REQ, PE_REQ;
  logic [7:0] NV_OPTION_BYTE, NV_PROTECT_BYTE, MEM_RDATA_RAW;
  logic [63:0] BACKDOOR_COMPARE_KEY;
  wire logic HSEL, HWRITE, HREADYOUT, HRESP, BUS_FROM_SECURE, BUS_FROM_DEBUG;
  wire logic MEM_WRITE_EN, DEBUG_MODULE_EN, ACTIVE_BACKGROUND_EN;
  wire logic PE_GRANT, PE_TIMING_PULSE, SECURED;
  wire logic [31:0] HADDR, HWDATA, HRDATA;
  wire logic [1:0] HTRANS;
  wire logic [2:0] HSIZE;
  wire logic [7:0] MEM_RDATA, PROTECT_OUT;
  wire logic HREADY = HREADYOUT;
  int bad_count = 0;
  int total_checks = 0;
  flash_security_ctl dut (.*);
  ahb_core_model m (.*);
  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rst(input logic [7:0] opt, input logic pin);
    @(posedge CORE_CLK);
    SYS_RST <= 1'b1;
    NV_OPTION_BYTE <= opt;
    BACKGROUND_MODE_SELECT_PIN <= pin;
    repeat (16) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
  endtask : rst
  task automatic mem(input logic w, input logic s);
    @(posedge CORE_CLK);
    MEM_REQ <= 1'b1;
    MEM_WRITE <= w;
    MEM_FROM_SECURE <= s;
    @(posedge CORE_CLK);
    MEM_REQ <= 1'b0;
    @(negedge CORE_CLK);
  endtask : mem
  task automatic t_gate;
    logic [31:0] q;
    rst(8'hc3, 1'b0);
    chk(SECURED, 1'b1);
    chk(ACTIVE_BACKGROUND_EN, 1'b1);
    m.xfer(1'b0, flash_sec_pkg::OFF_OPTION, 8'h00, 1'b1, 1'b0, q);
    chk(q, 32'hc3);
    mem(1'b0, 1'b0);
    chk(MEM_RDATA, 8'h00);
    mem(1'b1, 1'b0);
    chk(MEM_WRITE_EN, 1'b0);
    mem(1'b0, 1'b1);
    chk(MEM_RDATA, 8'h5a);
    @(posedge CORE_CLK);
    DEBUG_MODULE_REQ <= 1'b1;
    mem(1'b1, 1'b1);
    chk(MEM_WRITE_EN, 1'b1);
    chk(DEBUG_MODULE_EN, 1'b0);
    m.xfer(1'b1, flash_sec_pkg::OFF_PROTECT, 8'h68, 1'b1, 1'b0, q);
    @(negedge CORE_CLK);
    chk(PROTECT_OUT, 8'hf8);
    chk({HREADYOUT, HRESP}, 2'b10);
    m.xfer(1'b1, flash_sec_pkg::OFF_PROTECT, 8'h68, 1'b0, 1'b1, q);
    m.xfer(1'b0, flash_sec_pkg::OFF_PROTECT, 8'h00, 1'b0, 1'b1, q);
    chk(q, 32'h68);
    m.xfer(1'b0, flash_sec_pkg::OFF_STATUS, 8'h00, 1'b1, 1'b0, q);
    chk(q, 32'h05);
  endtask : t_gate
  task automatic t_codes;
    for (int c = 0; c < 4; c++) begin
      rst({6'h00, 2'(c)}, 1'b1);
      chk(SECURED, c != 2);
      chk(DEBUG_MODULE_EN, c == 2);
      chk(ACTIVE_BACKGROUND_EN, 1'b0);
    end
  endtask : t_codes
  task automatic t_div(input logic [7:0] dv, input logic [31:0] per);
    logic [31:0] q;
    int n;
    rst(8'h83, 1'b1);
    @(posedge CORE_CLK);
    PE_REQ <= 1'b1;
    m.xfer(1'b0, flash_sec_pkg::OFF_CLK_DIV, 8'h00, 1'b1, 1'b0, q);
    chk(q, 32'h0);
    @(negedge CORE_CLK);
    chk(PE_GRANT, 1'b0);
    m.xfer(1'b1, flash_sec_pkg::OFF_CLK_DIV, dv, 1'b1, 1'b0, q);
    m.xfer(1'b1, flash_sec_pkg::OFF_CLK_DIV, ~dv, 1'b1, 1'b0, q);
    m.xfer(1'b0, flash_sec_pkg::OFF_CLK_DIV, 8'h00, 1'b1, 1'b0, q);
    chk(q, {24'h0, 1'b1, dv[6:0]});
    @(negedge CORE_CLK);
    chk(PE_GRANT, 1'b1);
    n = 0;
    while (PE_TIMING_PULSE !== 1'b1 && n < 1000) begin
      @(negedge CORE_CLK);
      n++;
    end
    n = 0;
    do begin
      @(negedge CORE_CLK);
      n++;
    end while (PE_TIMING_PULSE !== 1'b1 && n < 1000);
    chk(n, per);
    @(posedge CORE_CLK);
    PE_REQ <= 1'b0;
  endtask : t_div
  task automatic keys(input logic s, input logic g, input logic [7:0] flip);
    logic [31:0] q;
    m.xfer(1'b1, flash_sec_pkg::OFF_CONFIG, 8'h20, s, g, q);
    for (int k = 0; k < 8; k++)
      m.xfer(1'b1, flash_sec_pkg::OFF_KEY_BASE + 8'(4 * k),
             BACKDOOR_COMPARE_KEY[8*k +: 8] ^ (k == 7 ? flip : 8'h00),
             s, g, q);
    m.xfer(1'b1, flash_sec_pkg::OFF_CONFIG, 8'h00, s, g, q);
    repeat (4) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
  endtask : keys
  task automatic t_unlock;
    rst(8'h83, 1'b1);
    keys(1'b0, 1'b1, 8'h00);
    chk(SECURED, 1'b1);
    keys(1'b1, 1'b0, 8'h01);
    chk(SECURED, 1'b1);
    keys(1'b1, 1'b0, 8'h00);
    chk(SECURED, 1'b0);
    mem(1'b0, 1'b0);
    chk(MEM_RDATA, 8'h5a);
    rst(8'h03, 1'b1);
    keys(1'b1, 1'b0, 8'h00);
    chk(SECURED, 1'b1);
    @(posedge CORE_CLK);
    BLANK_CHECK_PASS <= 1'b1;
    @(posedge CORE_CLK);
    BLANK_CHECK_PASS <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    chk(SECURED, 1'b0);
  endtask : t_unlock
  initial begin
    SYS_RST = 1'b1;
    NV_OPTION_BYTE = 8'h00;
    NV_PROTECT_BYTE = 8'hf8;
    BACKDOOR_COMPARE_KEY = 64'h0123456789abcdef;
    BLANK_CHECK_PASS = 1'b0;
    BACKGROUND_MODE_SELECT_PIN = 1'b0;
    MEM_REQ = 1'b0;
    MEM_WRITE = 1'b0;
    MEM_FROM_SECURE = 1'b0;
    MEM_RDATA_RAW = 8'h5a;
    DEBUG_MODULE_REQ = 1'b0;
    PE_REQ = 1'b0;
    t_gate;
    t_codes;
    t_div(8'h83, 32'd4);
    t_div(8'h41, 32'd16);
    t_div(8'h80, 32'd1);
    t_div(8'h7f, 32'd512);
    t_unlock;
    complete_run;
  end
  initial begin
    #100000;
    bad_count++;
    complete_run;
  end
endmodule : test_flash_security_ctl
